// >>> input_capture_modes.sv
// input capture channel: prescaled, edge detect and interrupt-only modes
// Summary of operation
// RULE1: mode 100 captures every fourth rising edge, mode 101 every sixteenth.
// RULE2: stored count is the timer two to three clocks after the pin edge.
// RULE3: software should disable the module before choosing a prescaled mode.
// RULE4: changing into a prescaled mode keeps the edge prescaler count.
// RULE5: mode 001 stores a count on every rising and falling edge.
// RULE6: edge mode bypasses the prescaler and never touches the overflow flag.
// RULE7: edge mode ignores the interrupt count and interrupts on each capture.
// RULE8: mode 111 in sleep or idle interrupts on every rising edge.
// RULE9: interrupt-only mode stores nothing and leaves the fifo untouched.
// RULE10: interrupt-only wake interrupt drops when sleep or idle ends.
// RULE11: interrupt-only mode ignores the timebase select.
// RULE12: interrupt-only wakes on the first rising edge, no count, no prescaler.
// RULE13: other capture modes interrupt after one to four stored captures.
// RULE14: buffer not empty flag is high while an unread capture remains.
// RULE15: timebase select 0 picks the second timer, 1 the first.
// RULE16: prescaler counts synchronized rising edges, clears while disabled.
// RULE17: the pin passes a two-stage synchronizer before edge detection.
`timescale 1ns/1ps
module input_capture_modes #(
  parameter int TIMER_W = input_capture_pkg::TIMER_W,
  parameter int DEPTH   = input_capture_pkg::FIFO_DEPTH
) (
  input  wire logic                                    i_mclk,
  input  wire logic                                    i_resetn,
  input  wire logic                                    i_cap_pin,
  input  wire logic                                    i_module_enable,
  input  wire logic [input_capture_pkg::MODE_W-1:0]    i_capture_mode_select,
  input  wire logic [input_capture_pkg::ICI_W-1:0]     i_interrupt_count_select,
  input  wire logic                                    i_timebase_select,
  input  wire logic                                    i_first_edge_rising,
  input  wire logic                                    i_low_power,
  input  wire logic [TIMER_W-1:0]                      i_timer_first,
  input  wire logic [TIMER_W-1:0]                      i_timer_second,
  input  wire logic                                    i_fifo_read,
  output logic      [TIMER_W-1:0]                      o_capture_data,
  output logic                                         o_buffer_not_empty_flag,
  output logic                                         o_capture_overflow_flag,
  output logic                                         o_capture_irq,
  output logic                                         o_wake_irq
);
  import input_capture_pkg::*;

  capture_fifo_if #(.WIDTH(TIMER_W)) fifo_bus ();

  logic                 pin_s1_reg;
  logic                 pin_s2_reg;
  logic                 pin_prev_reg;
  logic [PRE_W-1:0]     pre_cnt_reg;
  logic [ICI_W-1:0]     cap_cnt_reg;
  logic                 ov_reg;
  logic                 irq_reg;
  logic                 wake_reg;
  logic                 every_started_reg;

  // synchronizer, first stage read only by the second
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      pin_s1_reg   <= 1'b0;
      pin_s2_reg   <= 1'b0;
      pin_prev_reg <= 1'b0;
    end else begin
      pin_s1_reg   <= i_cap_pin;   // [RULE17]
      pin_s2_reg   <= pin_s1_reg;
      pin_prev_reg <= pin_s2_reg;
    end
  end

  wire en         = i_module_enable;
  wire [2:0] mode = i_capture_mode_select;
  wire rise       = pin_s2_reg && !pin_prev_reg;   // [RULE17]
  wire fall       = !pin_s2_reg && pin_prev_reg;
  wire any_edge   = rise || fall;
  wire pre_hit4   = (pre_cnt_reg[1:0] == PRE4_MASK);
  wire pre_hit16  = (pre_cnt_reg == PRE16_LAST);
  wire first_ok   = i_first_edge_rising ? rise : fall;
  wire every_hit  = every_started_reg ? any_edge : first_ok;

  // capture decision per mode
  wire cap_edge   = (mode == MODE_EDGE) && any_edge;                 // [RULE5] [RULE6]
  wire cap_pre4   = (mode == MODE_PRE4) && rise && pre_hit4;         // [RULE1]
  wire cap_pre16  = (mode == MODE_PRE16) && rise && pre_hit16;       // [RULE1]
  wire cap_simple = ((mode == MODE_RISE) && rise) || ((mode == MODE_FALL) && fall)
                    || ((mode == MODE_EVERY) && every_hit);
  wire capture    = en && (cap_edge || cap_pre4 || cap_pre16 || cap_simple);  // [RULE9]
  wire [TIMER_W-1:0] timer_sel = i_timebase_select ? i_timer_first
                                                   : i_timer_second;  // [RULE15]

  // timer sampled in the cycle the synchronized edge is seen
  assign fifo_bus.push_valid = capture;                              // [RULE2]
  assign fifo_bus.push_data  = timer_sel;
  assign fifo_bus.pop_ready  = i_fifo_read;
  wire push_fire  = capture && fifo_bus.push_ready;
  wire lost       = capture && !fifo_bus.push_ready && (mode != MODE_EDGE);  // [RULE6]
  wire cnt_done   = (cap_cnt_reg == i_interrupt_count_select);
  wire irq_next   = push_fire && ((mode == MODE_EDGE) || cnt_done);  // [RULE7] [RULE13]

  capture_fifo #(
    .WIDTH(TIMER_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .i_mclk   (i_mclk),
    .i_resetn (i_resetn),
    .i_flush  (!en),
    .fifo     (fifo_bus)
  );

  // prescaler counts rising edges in every enabled mode; no reset on mode change
  always_ff @(posedge i_mclk) begin
    if (!i_resetn || !en) begin
      pre_cnt_reg <= PRE_ZERO;                                       // [RULE16]
    end else if (rise) begin
      pre_cnt_reg <= pre_cnt_reg + PRE_ONE;                          // [RULE4] [RULE16]
    end
  end

  // capture counter for interrupt grouping
  always_ff @(posedge i_mclk) begin
    if (!i_resetn || !en) begin
      cap_cnt_reg <= CNT_ZERO;
    end else if (push_fire && mode != MODE_EDGE) begin
      cap_cnt_reg <= cnt_done ? CNT_ZERO : cap_cnt_reg + CNT_ONE;    // [RULE13]
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_resetn || !en || mode != MODE_EVERY) begin
      every_started_reg <= 1'b0;
    end else if (first_ok) begin
      every_started_reg <= 1'b1;
    end
  end

  // overflow: set wins over the disable clear
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      ov_reg <= 1'b0;
    end else if (lost) begin
      ov_reg <= 1'b1;                                                // [RULE6]
    end else if (!en) begin
      ov_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
    end
  end

  // wake interrupt level: timebase and count select play no part
  wire wake_set = en && (mode == MODE_INT_ONLY) && i_low_power && rise;  // [RULE8] [RULE11] [RULE12]
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      wake_reg <= 1'b0;
    end else if (wake_set) begin
      wake_reg <= 1'b1;
    end else if (!i_low_power || !en || mode != MODE_INT_ONLY) begin
      wake_reg <= 1'b0;                                              // [RULE10]
    end
  end

  assign o_capture_data          = fifo_bus.pop_data;
  assign o_buffer_not_empty_flag = fifo_bus.pop_valid;               // [RULE14]
  assign o_capture_overflow_flag = ov_reg;
  assign o_capture_irq           = irq_reg;
  assign o_wake_irq              = wake_reg;

  sequence s_rise_in_sleep;
    en && mode == MODE_INT_ONLY && i_low_power && rise;
  endsequence

  sequence s_store_first;
    push_fire && !fifo_bus.pop_valid;
  endsequence

  property p_sync;
    @(posedge i_mclk) disable iff (!i_resetn)
      ##2 (pin_s2_reg == $past(i_cap_pin, 2));
  endproperty
  a_sync: assert property (p_sync) else $error("synchronizer depth wrong");  // [RULE17]

  property p_pre4;
    @(posedge i_mclk) disable iff (!i_resetn)
      (en && mode == MODE_PRE4 && rise) |-> (fifo_bus.push_valid == pre_hit4);
  endproperty
  a_pre4: assert property (p_pre4) else $error("prescale by four wrong");  // [RULE1]

  property p_edge_every;
    @(posedge i_mclk) disable iff (!i_resetn)
      (en && mode == MODE_EDGE && any_edge) |-> fifo_bus.push_valid;
  endproperty
  a_edge_every: assert property (p_edge_every) else $error("edge not captured");  // [RULE5]

  property p_edge_no_ov;
    @(posedge i_mclk) disable iff (!i_resetn)
      (en && mode == MODE_EDGE) |=> !$rose(ov_reg);
  endproperty
  a_edge_no_ov: assert property (p_edge_no_ov) else $error("overflow set in edge mode");  // [RULE6]

  property p_edge_irq;
    @(posedge i_mclk) disable iff (!i_resetn)
      (mode == MODE_EDGE && push_fire) |=> o_capture_irq;
  endproperty
  a_edge_irq: assert property (p_edge_irq) else $error("edge capture missed irq");  // [RULE7]

  property p_wake;
    @(posedge i_mclk) disable iff (!i_resetn)
      s_rise_in_sleep |=> o_wake_irq ##0 !fifo_bus.push_valid;
  endproperty
  a_wake: assert property (p_wake) else $error("wake irq missing");  // [RULE8] [RULE12]

  property p_int_nostore;
    @(posedge i_mclk) disable iff (!i_resetn)
      (mode == MODE_INT_ONLY) |-> !fifo_bus.push_valid;
  endproperty
  a_int_nostore: assert property (p_int_nostore) else $error("store in int mode");  // [RULE9]

  property p_wake_drop;
    @(posedge i_mclk) disable iff (!i_resetn)
      (o_wake_irq && !i_low_power) |=> !o_wake_irq;
  endproperty
  a_wake_drop: assert property (p_wake_drop) else $error("wake irq held awake");  // [RULE10]

  property p_ici;
    @(posedge i_mclk) disable iff (!i_resetn)
      (push_fire && mode != MODE_EDGE) |=> (o_capture_irq == $past(cnt_done));
  endproperty
  a_ici: assert property (p_ici) else $error("capture count irq wrong");  // [RULE13]

  property p_bne;
    @(posedge i_mclk) disable iff (!i_resetn)
      s_store_first ##1 en |-> o_buffer_not_empty_flag;
  endproperty
  a_bne: assert property (p_bne) else $error("not empty flag missing");  // [RULE14]

  property p_pre_clear;
    @(posedge i_mclk) disable iff (!i_resetn)
      !en |=> (pre_cnt_reg == PRE_ZERO);
  endproperty
  a_pre_clear: assert property (p_pre_clear) else $error("prescaler not cleared");  // [RULE16]

  property p_pre_keep;
    @(posedge i_mclk) disable iff (!i_resetn)
      (en && !rise && mode != $past(mode)) |=> $stable(pre_cnt_reg) || !en;
  endproperty
  a_pre_keep: assert property (p_pre_keep) else $error("prescaler reset by mode");  // [RULE4]

  property p_tsel;
    @(posedge i_mclk) disable iff (!i_resetn)
      fifo_bus.push_valid |-> fifo_bus.push_data
        == (i_timebase_select ? i_timer_first : i_timer_second);
  endproperty
  a_tsel: assert property (p_tsel) else $error("timebase wrong");  // [RULE15] [RULE2]
endmodule : input_capture_modes

// >>> input_capture_pkg.sv
// constants shared by the input capture channel
package input_capture_pkg;
  localparam int          TIMER_W       = 16;
  localparam int          FIFO_DEPTH    = 8;
  localparam int          MODE_W        = 3;
  localparam int          ICI_W         = 2;
  localparam int          PRE_W         = 4;
  localparam logic [2:0]  MODE_OFF      = 3'h0;
  localparam logic [2:0]  MODE_EDGE     = 3'h1;
  localparam logic [2:0]  MODE_FALL     = 3'h2;
  localparam logic [2:0]  MODE_RISE     = 3'h3;
  localparam logic [2:0]  MODE_PRE4     = 3'h4;
  localparam logic [2:0]  MODE_PRE16    = 3'h5;
  localparam logic [2:0]  MODE_EVERY    = 3'h6;
  localparam logic [2:0]  MODE_INT_ONLY = 3'h7;
  localparam logic [3:0]  PRE4_LAST     = 4'h3;
  localparam logic [3:0]  PRE16_LAST    = 4'hF;
  localparam logic [1:0]  PRE4_MASK     = 2'h3;
  localparam logic [3:0]  PRE_ZERO      = 4'h0;
  localparam logic [3:0]  PRE_ONE       = 4'h1;
  localparam logic [1:0]  CNT_ZERO      = 2'h0;
  localparam logic [1:0]  CNT_ONE       = 2'h1;
endpackage : input_capture_pkg

// >>> capture_fifo_if.sv
// push and pop handshake between the capture logic and its result fifo
`timescale 1ns/1ps
interface capture_fifo_if #(parameter int WIDTH = 16);
  logic             push_valid;
  logic             push_ready;
  logic [WIDTH-1:0] push_data;
  logic             pop_valid;
  logic             pop_ready;
  logic [WIDTH-1:0] pop_data;
  modport producer (output push_valid, push_data, input push_ready,
                    input pop_valid, pop_data, output pop_ready);
  modport store (input push_valid, push_data, output push_ready,
                 output pop_valid, pop_data, input pop_ready);
endinterface : capture_fifo_if

// >>> capture_fifo.sv
// capture result fifo with valid/ready on both sides
`timescale 1ns/1ps
module capture_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic           i_mclk,
  input  wire logic           i_resetn,
  input  wire logic           i_flush,
  capture_fifo_if.store       fifo
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    rd_reg;
  logic [AW:0]      cnt_reg;
  wire              push_fire = fifo.push_valid && fifo.push_ready;
  wire              pop_fire  = fifo.pop_valid && fifo.pop_ready;

  assign fifo.push_ready = (cnt_reg != (AW+1)'(DEPTH));
  assign fifo.pop_valid  = (cnt_reg != '0);
  assign fifo.pop_data   = mem[rd_reg];

  always_ff @(posedge i_mclk) begin
    if (push_fire) begin
      mem[wr_reg] <= fifo.push_data;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_resetn || i_flush) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (push_fire) begin
        wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
      end
      if (pop_fire) begin
        rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW+1)'(push_fire) - (AW+1)'(pop_fire);
    end
  end
endmodule : capture_fifo

// >>> capture_source_model.sv
// far side model: free-running timers and the capture pin
`timescale 1ns/1ps
module capture_source_model #(
  parameter int TIMER_W = 16
) (
  input  wire logic               i_mclk,
  input  wire logic               i_resetn,
  input  wire logic               i_pin_level,
  output logic                    o_cap_pin,
  output logic      [TIMER_W-1:0] o_timer_first,
  output logic      [TIMER_W-1:0] o_timer_second
);
  logic [TIMER_W-1:0] first_reg;
  logic [TIMER_W-1:0] second_reg;
  // pin level as commanded by the bench, spaced by at least two clocks
  assign o_cap_pin      = i_pin_level;
  assign o_timer_first  = first_reg;
  assign o_timer_second = second_reg;
  // two timers moving apart so a wrong timebase shows
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      first_reg  <= '0;
      second_reg <= '1;
    end else begin
      first_reg  <= first_reg + TIMER_W'(1);
      second_reg <= second_reg - TIMER_W'(3);
    end
  end
endmodule : capture_source_model

// >>> input_capture_modes_bench.sv
// self-checking bench for the input capture channel
`timescale 1ns/1ps
module input_capture_modes_bench;
  import input_capture_pkg::*;
  logic               i_mclk, i_resetn, pin_level, cap_pin, i_module_enable;
  logic [MODE_W-1:0]  i_capture_mode_select;
  logic [ICI_W-1:0]   i_interrupt_count_select;
  logic               i_timebase_select, i_low_power, i_fifo_read;
  logic [TIMER_W-1:0] timer_first, timer_second, o_capture_data;
  logic               o_buffer_not_empty_flag, o_capture_overflow_flag;
  logic               o_capture_irq, o_wake_irq, ovf_exp;
  logic [TIMER_W-1:0] q[$];
  integer             seed = 3;
  int                 errors, comparisons, irq_seen, irq_exp, pre, cnt;

  capture_source_model source (.i_mclk(i_mclk), .i_resetn(i_resetn),
    .i_pin_level(pin_level), .o_cap_pin(cap_pin), .o_timer_first(timer_first),
    .o_timer_second(timer_second));
  input_capture_modes DUT (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_cap_pin(cap_pin),
    .i_module_enable(i_module_enable), .i_capture_mode_select(i_capture_mode_select),
    .i_interrupt_count_select(i_interrupt_count_select),
    .i_timebase_select(i_timebase_select), .i_first_edge_rising(1'b1),
    .i_low_power(i_low_power), .i_timer_first(timer_first),
    .i_timer_second(timer_second), .i_fifo_read(i_fifo_read),
    .o_capture_data(o_capture_data), .o_buffer_not_empty_flag(o_buffer_not_empty_flag),
    .o_capture_overflow_flag(o_capture_overflow_flag), .o_capture_irq(o_capture_irq),
    .o_wake_irq(o_wake_irq));

  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end
  // irq pulse counted at the falling edge after the rising edge that launches it
  always @(negedge i_mclk) if (o_capture_irq === 1'b1) irq_seen++;

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task report_and_stop;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop

  task set_mode(input logic en, input logic [2:0] mode, input logic tb, input int interrupt_count_select);
    @(negedge i_mclk);
    i_module_enable = en;
    i_capture_mode_select = mode;
    i_timebase_select = tb;
    i_interrupt_count_select = interrupt_count_select[1:0];
    if (!en) begin
      pre = 0;
      cnt = 0;
      q.delete();
      ovf_exp = 1'b0;
    end
    @(negedge i_mclk);
  endtask : set_mode

  // one pin edge; the expected stamp is the timer two clocks after it
  task toggle_pin;
    logic [TIMER_W-1:0] stamp;
    logic               rise, capture;
    @(negedge i_mclk);
    pin_level = ~pin_level;
    rise = pin_level;
    repeat (2) @(negedge i_mclk);
    stamp = i_timebase_select ? timer_first : timer_second;
    capture = (i_capture_mode_select == MODE_EDGE);
    if (rise && i_capture_mode_select == MODE_PRE4) begin
      capture = (pre % 4 == 3);
      pre = (pre + 1) % 16;
    end
    if (rise && i_capture_mode_select == MODE_PRE16) begin
      capture = (pre == 15);
      pre = (pre + 1) % 16;
    end
    if (capture && q.size() < FIFO_DEPTH) begin
      q.push_back(stamp);
      cnt++;
      if (i_capture_mode_select == MODE_EDGE || cnt == i_interrupt_count_select + 1) begin
        irq_exp++;
        cnt = 0;
      end
    end else if (capture && i_capture_mode_select != MODE_EDGE) ovf_exp = 1'b1;
    repeat (2 + ($random(seed) & 3)) @(negedge i_mclk);
  endtask : toggle_pin

  task toggles(input int n);
    repeat (n) toggle_pin();
  endtask : toggles

  task drain;
    while (q.size() > 0) begin
      check("not_empty", 32'(o_buffer_not_empty_flag), 32'h1);
      check("capture_data", 32'(o_capture_data), 32'(q.pop_front()));
      i_fifo_read = 1'b1;
      @(negedge i_mclk);
    end
    i_fifo_read = 1'b0;
    check("not_empty", 32'(o_buffer_not_empty_flag), 32'h0);
  endtask : drain

  task check_flags;
    check("overflow", 32'(o_capture_overflow_flag), 32'(ovf_exp));
    check("irq_count", 32'(irq_seen), 32'(irq_exp));
  endtask : check_flags

  initial begin
    repeat (20000) @(posedge i_mclk);
    errors++;
    report_and_stop();
  end

  initial begin
    {i_resetn, pin_level, i_module_enable, i_timebase_select} = 4'h0;
    {i_low_power, i_fifo_read, i_capture_mode_select, i_interrupt_count_select} = 7'h00;
    {ovf_exp, irq_seen, irq_exp, pre, cnt, errors, comparisons} = '0;
    repeat (2) @(negedge i_mclk);
    i_resetn = 1'b1;
    repeat (3) @(negedge i_mclk);
    check("not_empty", 32'(o_buffer_not_empty_flag), 32'h0);
    set_mode(1'b1, MODE_EDGE, 1'b0, $random(seed));
    toggles(6);
    check_flags();
    drain();
    toggles(10);
    check_flags();
    drain();
    {irq_seen, irq_exp} = '0;
    set_mode(1'b0, MODE_OFF, 1'b1, 0);
    set_mode(1'b1, MODE_PRE4, 1'b1, $random(seed));
    toggles(64);
    check_flags();
    toggles(8);
    check_flags();
    drain();
    {irq_seen, irq_exp} = '0;
    set_mode(1'b0, MODE_OFF, 1'b1, 0);
    check_flags();
    set_mode(1'b1, MODE_PRE4, 1'b1, 0);
    toggles(4);
    set_mode(1'b1, MODE_PRE16, 1'b1, 0);
    toggles(28);
    check_flags();
    drain();
    set_mode(1'b0, MODE_OFF, 1'b1, 0);
    set_mode(1'b1, MODE_PRE4, 1'b1, 0);
    toggles(8);
    check_flags();
    drain();
    set_mode(1'b1, MODE_INT_ONLY, 1'($random(seed)), $random(seed));
    if (pin_level) toggle_pin();
    toggle_pin();
    check("wake", 32'(o_wake_irq), 32'h0);
    toggle_pin();
    i_low_power = 1'b1;
    toggle_pin();
    check("wake", 32'(o_wake_irq), 32'h1);
    check("not_empty", 32'(o_buffer_not_empty_flag), 32'h0);
    check_flags();
    i_low_power = 1'b0;
    repeat (2) @(negedge i_mclk);
    check("wake", 32'(o_wake_irq), 32'h0);
    report_and_stop();
  end
endmodule : input_capture_modes_bench
